//--- include/gpio_bc_map.vh
// Register indices, field masks, reset values and timing for the port B
// and port C pin block. Included by bare name from the register block.
`ifndef GPIO_BC_MAP_VH
`define GPIO_BC_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define PORT_B_OUTPUT_LATCH_IDX   10'h2cc
`define PORT_B_OPEN_DRAIN_CTL_IDX 10'h2ce
`define PORT_C_DIRECTION_IDX      10'h2d0
`define PORT_C_PIN_LEVELS_IDX     10'h2d2
`define PORT_C_OUTPUT_LATCH_IDX   10'h2d4
`define PORT_C_OPEN_DRAIN_CTL_IDX 10'h2d6

// ----------------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------------
`define PORT_B_IMPL_MASK          16'hffff
`define PORT_C_IMPL_MASK          16'hf01e
`define PORT_C_DIR_MASK           16'h901e
`define PORT_C_INPUT_ONLY_MASK    16'h6000
`define PORT_C_BIT_TWELVE         12
`define PORT_C_BIT_FIFTEEN        15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PORT_C_DIRECTION_RESET    16'h901e
`define OPEN_DRAIN_CTL_RESET      16'h0000
`define OUTPUT_LATCH_RESET        16'h0000

// ----------------------------------------------------------------------
// Primary oscillator mode codes that free the oscillator pins, and the pin function value that frees bit 15
// ----------------------------------------------------------------------
`define OSC_MODE_OFF              2'h3
`define OSC_MODE_EXT_CLOCK        2'h0
`define OSC_PIN_FN_PORT           1'h1

// ----------------------------------------------------------------------
// Bus timing: wait states before the answer of every access
// ----------------------------------------------------------------------
`define BUS_WAIT_STATES           1

`endif

//--- hdl/pin_drive.v
// Output stage for a group of general purpose pins.
// Assumes direction, latch and open-drain inputs are synchronous to clk_i
// and that rst_n_i is an already synchronised active-low reset.
module pin_drive #(
   parameter W = 16
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] dir_i,
   input  wire [W-1:0] lat_i,
   input  wire [W-1:0] odc_i,
   input  wire [W-1:0] en_i,
   output reg  [W-1:0] pin_o,
   output reg  [W-1:0] pin_oe_n_o
);

   // -------------------------------------------------------------------
   // Drive decision
   // -------------------------------------------------------------------
   // An open-drain pin with a high latch bit is released, not driven high,
   // so the external pull-up decides its level.
   wire [W-1:0] drive_w;
   wire [W-1:0] value_w;

   assign drive_w = en_i & ~dir_i & ~(odc_i & lat_i);
   assign value_w = lat_i & ~odc_i;

   // -------------------------------------------------------------------
   // Registered pin outputs
   // -------------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_o      <= {W{1'b0}};
         pin_oe_n_o <= {W{1'b1}};
      end else begin
         pin_o      <= value_w & drive_w;
         pin_oe_n_o <= ~drive_w;
      end
   end

endmodule

//--- hdl/gpio_bc_regs.v
// Port B and port C pin registers behind an Avalon-MM slave.
// Assumes pin inputs and configuration levels are synchronous to CLK_I,
// and that the port B direction comes from a register kept elsewhere.
//
// Contract
// - Unimplemented port C bits read zero, ignore writes
// - C12, C15 read pins only in modes 11/00
// - C15 also needs oscillator pin function bit 1
// - C13, C14 are never driven
// - Port C direction resets to 901e
// - Both open-drain controls reset to 0000
// - Latches and pin sample need no reset value
// - Decode 02cc, 02ce and 02d0 to 02d6
`include "gpio_bc_map.vh"

module gpio_bc_regs (
   input  wire        CLK_I,
   input  wire        ARST_N_I,
   input  wire [11:0] AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   output reg  [31:0] AVS_READDATA_O,
   output wire        AVS_WAITREQUEST_O,
   input  wire [1:0]  PRIMARY_OSC_MODE_CFG_I,
   input  wire        OSC_PIN_FUNCTION_CFG_I,
   input  wire [15:0] PORT_B_DIR_I,
   output wire [15:0] PORT_B_PIN_O,
   output wire [15:0] PORT_B_PIN_OE_N_O,
   input  wire [15:0] PORT_C_PIN_I,
   output wire [15:0] PORT_C_PIN_O,
   output wire [15:0] PORT_C_PIN_OE_N_O
);

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   // The reset is asserted at once but released through two flip-flops,
   // so that no register leaves reset on a partial clock edge.
   reg rst_meta_q;
   reg rst_n_q;

   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // -------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------
   reg [15:0] port_b_output_latch_q;
   reg [15:0] port_b_open_drain_ctl_q;
   reg [15:0] port_c_direction_q;
   reg [15:0] port_c_pin_levels_q;
   reg [15:0] port_c_output_latch_q;
   reg [15:0] port_c_open_drain_ctl_q;

   reg [15:0] port_b_output_latch_d;
   reg [15:0] port_b_open_drain_ctl_d;
   reg [15:0] port_c_direction_d;
   reg [15:0] port_c_output_latch_d;
   reg [15:0] port_c_open_drain_ctl_d;

   // -------------------------------------------------------------------
   // Oscillator pin availability
   // -------------------------------------------------------------------
   // Bits 12 and 15 double as oscillator pins. They are free only while
   // the primary oscillator is off or fed by an external clock; bit 15
   // also needs the oscillator pin function set to port use.
   wire        osc_pins_free_w;
   wire        bit_fifteen_free_w;
   reg  [15:0] avail_mask_w;
   reg  [15:0] drive_en_w;

   assign osc_pins_free_w =
      (PRIMARY_OSC_MODE_CFG_I == `OSC_MODE_OFF) ||
      (PRIMARY_OSC_MODE_CFG_I == `OSC_MODE_EXT_CLOCK);

   assign bit_fifteen_free_w = osc_pins_free_w &&
      (OSC_PIN_FUNCTION_CFG_I == `OSC_PIN_FN_PORT);

   always @* begin
      avail_mask_w = `PORT_C_IMPL_MASK;
      avail_mask_w[`PORT_C_BIT_TWELVE] = osc_pins_free_w;
      avail_mask_w[`PORT_C_BIT_FIFTEEN] = bit_fifteen_free_w;
   end

   // Input-only pins are left out of the drive enable entirely, so no
   // direction or latch setting can ever turn their drivers on.
   always @* begin
      drive_en_w = avail_mask_w & ~`PORT_C_INPUT_ONLY_MASK;
   end

   // -------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------
   // Every access takes one wait state. Read data are captured in the
   // first cycle and a write takes effect on the edge at which
   // waitrequest is seen low, exactly when the master lets go.
   reg  ack_q;
   wire req_w;
   wire wr_fire_w;
   wire rd_cap_w;

   assign req_w             = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req_w & ~ack_q;
   assign wr_fire_w         = AVS_WRITE_I & ack_q;
   assign rd_cap_w          = AVS_READ_I & ~ack_q;

   always @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ack_q <= 1'b0;
      end else if (ack_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w;
      end
   end

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   wire [9:0] idx_w;
   wire       addr_aligned_w;
   wire       sel_b_lat_w;
   wire       sel_b_odc_w;
   wire       sel_c_dir_w;
   wire       sel_c_pin_w;
   wire       sel_c_lat_w;
   wire       sel_c_odc_w;

   assign idx_w          = AVS_ADDRESS_I[11:2];
   assign addr_aligned_w = (AVS_ADDRESS_I[1:0] == 2'h0);
   assign sel_b_lat_w    = addr_aligned_w &&
                           (idx_w == `PORT_B_OUTPUT_LATCH_IDX);
   assign sel_b_odc_w    = addr_aligned_w &&
                           (idx_w == `PORT_B_OPEN_DRAIN_CTL_IDX);
   assign sel_c_dir_w    = addr_aligned_w &&
                           (idx_w == `PORT_C_DIRECTION_IDX);
   assign sel_c_pin_w    = addr_aligned_w &&
                           (idx_w == `PORT_C_PIN_LEVELS_IDX);
   assign sel_c_lat_w    = addr_aligned_w &&
                           (idx_w == `PORT_C_OUTPUT_LATCH_IDX);
   assign sel_c_odc_w    = addr_aligned_w &&
                           (idx_w == `PORT_C_OPEN_DRAIN_CTL_IDX);

   // -------------------------------------------------------------------
   // Byte-lane merge
   // -------------------------------------------------------------------
   // Only the two low byte lanes carry register data; the upper lanes
   // of a 32-bit write are accepted and dropped.
   function [15:0] merge_lanes;
      input [15:0] old_val;
      input [31:0] wdata;
      input [3:0]  be;
      input [15:0] impl;
      reg   [15:0] lane_mask;
      begin
         lane_mask   = {{8{be[1]}}, {8{be[0]}}} & impl;
         merge_lanes = (old_val & ~lane_mask) | (wdata[15:0] & lane_mask);
      end
   endfunction

   // -------------------------------------------------------------------
   // Next register values
   // -------------------------------------------------------------------
   always @* begin
      port_b_output_latch_d   = port_b_output_latch_q;
      port_b_open_drain_ctl_d = port_b_open_drain_ctl_q;
      port_c_direction_d      = port_c_direction_q;
      port_c_output_latch_d   = port_c_output_latch_q;
      port_c_open_drain_ctl_d = port_c_open_drain_ctl_q;
      if (wr_fire_w) begin
         if (sel_b_lat_w) begin
            port_b_output_latch_d = merge_lanes(port_b_output_latch_q,
               AVS_WRITEDATA_I, AVS_BYTEENABLE_I, `PORT_B_IMPL_MASK);
         end
         if (sel_b_odc_w) begin
            port_b_open_drain_ctl_d = merge_lanes(port_b_open_drain_ctl_q,
               AVS_WRITEDATA_I, AVS_BYTEENABLE_I, `PORT_B_IMPL_MASK);
         end
         if (sel_c_dir_w) begin
            port_c_direction_d = merge_lanes(port_c_direction_q,
               AVS_WRITEDATA_I, AVS_BYTEENABLE_I, `PORT_C_DIR_MASK);
         end
         // A write to the pin register lands in the latch, as the pin
         // levels themselves cannot be stored.
         if (sel_c_lat_w || sel_c_pin_w) begin
            port_c_output_latch_d = merge_lanes(port_c_output_latch_q,
               AVS_WRITEDATA_I, AVS_BYTEENABLE_I, `PORT_C_IMPL_MASK);
         end
         if (sel_c_odc_w) begin
            port_c_open_drain_ctl_d = merge_lanes(port_c_open_drain_ctl_q,
               AVS_WRITEDATA_I, AVS_BYTEENABLE_I, `PORT_C_IMPL_MASK);
         end
      end
   end

   // -------------------------------------------------------------------
   // Control registers with documented reset values
   // -------------------------------------------------------------------
   always @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port_c_direction_q      <= `PORT_C_DIRECTION_RESET;
         port_b_open_drain_ctl_q <= `OPEN_DRAIN_CTL_RESET;
         port_c_open_drain_ctl_q <= `OPEN_DRAIN_CTL_RESET;
      end else begin
         port_c_direction_q      <= port_c_direction_d;
         port_b_open_drain_ctl_q <= port_b_open_drain_ctl_d;
         port_c_open_drain_ctl_q <= port_c_open_drain_ctl_d;
      end
   end

   // -------------------------------------------------------------------
   // Output latches
   // -------------------------------------------------------------------
   // Software may not rely on the latch contents after reset. They are
   // still cleared, so that simulation and silicon agree; with every drivable
   // port C direction bit set at reset the port C value never reaches a pin,
   // while port B pins follow PORT_B_DIR_I.
   always @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port_b_output_latch_q <= `OUTPUT_LATCH_RESET;
         port_c_output_latch_q <= `OUTPUT_LATCH_RESET;
      end else begin
         port_b_output_latch_q <= port_b_output_latch_d;
         port_c_output_latch_q <= port_c_output_latch_d;
      end
   end

   // -------------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------------
   // Pins are sampled every cycle whatever the direction, so a read
   // shows the real pad level, including an open-drain pin held low
   // by another device.
   always @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port_c_pin_levels_q <= `OUTPUT_LATCH_RESET;
      end else begin
         port_c_pin_levels_q <= PORT_C_PIN_I & avail_mask_w;
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   reg [15:0] rd_mux_w;

   always @* begin
      rd_mux_w = 16'h0000;
      if (sel_b_lat_w) begin
         rd_mux_w = port_b_output_latch_q;
      end else if (sel_b_odc_w) begin
         rd_mux_w = port_b_open_drain_ctl_q;
      end else if (sel_c_dir_w) begin
         rd_mux_w = port_c_direction_q & `PORT_C_DIR_MASK;
      end else if (sel_c_pin_w) begin
         rd_mux_w = port_c_pin_levels_q & avail_mask_w;
      end else if (sel_c_lat_w) begin
         rd_mux_w = port_c_output_latch_q & `PORT_C_IMPL_MASK;
      end else if (sel_c_odc_w) begin
         rd_mux_w = port_c_open_drain_ctl_q & `PORT_C_IMPL_MASK;
      end
   end

   // Unmapped addresses answer with zero after the same wait state, so a
   // stray access never hangs the bus.
   always @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         AVS_READDATA_O <= 32'h00000000;
      end else if (rd_cap_w) begin
         AVS_READDATA_O <= {16'h0000, rd_mux_w};
      end
   end

   // -------------------------------------------------------------------
   // Pin output stages
   // -------------------------------------------------------------------
   pin_drive #(
      .W (16)
   ) u_port_b_drive (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n_q),
      .dir_i      (PORT_B_DIR_I),
      .lat_i      (port_b_output_latch_q),
      .odc_i      (port_b_open_drain_ctl_q),
      .en_i       (`PORT_B_IMPL_MASK),
      .pin_o      (PORT_B_PIN_O),
      .pin_oe_n_o (PORT_B_PIN_OE_N_O)
   );

   pin_drive #(
      .W (16)
   ) u_port_c_drive (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n_q),
      .dir_i      (port_c_direction_q),
      .lat_i      (port_c_output_latch_q),
      .odc_i      (port_c_open_drain_ctl_q),
      .en_i       (drive_en_w),
      .pin_o      (PORT_C_PIN_O),
      .pin_oe_n_o (PORT_C_PIN_OE_N_O)
   );

endmodule

//--- verif/gpio_bc_regs_asserts.sv
// Port-level checks for the port B and port C pin block.
// Assumes it is bound to gpio_bc_regs and sees only that module's ports.
module gpio_bc_regs_asserts (
   input wire        CLK_I,
   input wire        ARST_N_I,
   input wire [11:0] AVS_ADDRESS_I,
   input wire        AVS_READ_I,
   input wire        AVS_WRITE_I,
   input wire [31:0] AVS_READDATA_O,
   input wire        AVS_WAITREQUEST_O,
   input wire [1:0]  PRIMARY_OSC_MODE_CFG_I,
   input wire        OSC_PIN_FUNCTION_CFG_I,
   input wire [15:0] PORT_B_DIR_I,
   input wire [15:0] PORT_B_PIN_O,
   input wire [15:0] PORT_B_PIN_OE_N_O,
   input wire [15:0] PORT_C_PIN_O,
   input wire [15:0] PORT_C_PIN_OE_N_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire req     = AVS_READ_I | AVS_WRITE_I;
   wire rd_done = AVS_READ_I & ~AVS_WAITREQUEST_O;
   wire free    = PRIMARY_OSC_MODE_CFG_I == 2'h3 ||
                  PRIMARY_OSC_MODE_CFG_I == 2'h0;
   wire c_group = AVS_ADDRESS_I[11:4] == 8'hb4 ||
                  AVS_ADDRESS_I[11:4] == 8'hb5;
   sequence s_req_start;
      $rose(req) ##0 AVS_WAITREQUEST_O;
   endsequence
   sequence s_answer;
      !AVS_WAITREQUEST_O;
   endsequence
   a_wait_once: assert property (s_req_start |=> s_answer)
      else $error("waitrequest not low in second request cycle");
   a_wait_first: assert property ($rose(req) |-> s_req_start)
      else $error("waitrequest not high in first request cycle");
   a_unmapped_zero: assert property (
      rd_done && AVS_ADDRESS_I[1:0] != 2'h0 |-> AVS_READDATA_O == 32'h0)
      else $error("misaligned read returned nonzero data");
   a_upper_zero: assert property (
      rd_done |-> AVS_READDATA_O[31:16] == 16'h0)
      else $error("upper read half not zero");
   a_c_unimpl_rd: assert property (
      rd_done && c_group |-> (AVS_READDATA_O[15:0] & ~16'hf01e) == 16'h0)
      else $error("unimplemented port C bit read nonzero");
   a_input_only: assert property (PORT_C_PIN_OE_N_O[14:13] == 2'h3)
      else $error("input-only port C pin driven");
   a_unimpl_drive: assert property (
      (~PORT_C_PIN_OE_N_O & ~16'hf01e) == 16'h0)
      else $error("unimplemented port C pin driven");
   a_osc_pins: assert property (
      !free |=> PORT_C_PIN_OE_N_O[12] && PORT_C_PIN_OE_N_O[15])
      else $error("oscillator pin driven in oscillator mode");
   a_fn_pin: assert property (
      !OSC_PIN_FUNCTION_CFG_I |=> PORT_C_PIN_OE_N_O[15])
      else $error("bit 15 driven with pin function off");
   a_b_dir_in: assert property (
      ($past(PORT_B_DIR_I) & ~PORT_B_PIN_OE_N_O) == 16'h0)
      else $error("port B input pin driven");
   a_no_float_hi: assert property (
      (PORT_B_PIN_O & PORT_B_PIN_OE_N_O) == 16'h0 &&
      (PORT_C_PIN_O & PORT_C_PIN_OE_N_O) == 16'h0)
      else $error("pin high while not driven");
   a_reset_idle: assert property ($rose(ARST_N_I) |->
      &PORT_B_PIN_OE_N_O && &PORT_C_PIN_OE_N_O)
      else $error("pin driven right after reset");
endmodule

bind gpio_bc_regs gpio_bc_regs_asserts u_chk (
   .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .PRIMARY_OSC_MODE_CFG_I(PRIMARY_OSC_MODE_CFG_I),
   .OSC_PIN_FUNCTION_CFG_I(OSC_PIN_FUNCTION_CFG_I),
   .PORT_B_DIR_I(PORT_B_DIR_I), .PORT_B_PIN_O(PORT_B_PIN_O),
   .PORT_B_PIN_OE_N_O(PORT_B_PIN_OE_N_O), .PORT_C_PIN_O(PORT_C_PIN_O),
   .PORT_C_PIN_OE_N_O(PORT_C_PIN_OE_N_O));

//--- verif/pin_world.sv
// Circuitry outside the port C pins: a driven pin shows the block's level,
// an undriven one whatever outside level the bench chooses, so a stale
// value is never seen once the block lets go.
module pin_world (
   input  wire [15:0] pin_o_i,
   input  wire [15:0] oe_n_i,
   input  wire [15:0] ext_i,
   output wire [15:0] pin_i_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin_i_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_i);
endmodule

//--- verif/tb.sv
// Self-checking bench for gpio_bc_regs with random pin traffic.
// Assumes the checker is bound in and pin_world models the outside pins.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, arst_n = 0, rd = 0, wr = 0, fn = 0;
   logic [11:0] adr = 0;
   logic [31:0] wdat = 0;
   logic [3:0]  be = 0;
   logic [3:0]  bb;
   logic [15:0] wv;
   logic [1:0]  mode = 0;
   logic [15:0] bdir = 16'hffff, ext = 0, bl, bo, cd, cl, co, q, en, dc;
   wire  [31:0] rdat;
   wire         wt;
   wire  [15:0] bpin, boen, cpin_i, cpin, coen;
   integer      err_total = 0, checks_done = 0, cyc = 0, i, seed = 32'hf1af;

   gpio_bc_regs u_gpio_bc_regs (.CLK_I(clk), .ARST_N_I(arst_n),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wt), .PRIMARY_OSC_MODE_CFG_I(mode),
      .OSC_PIN_FUNCTION_CFG_I(fn), .PORT_B_DIR_I(bdir), .PORT_B_PIN_O(bpin),
      .PORT_B_PIN_OE_N_O(boen), .PORT_C_PIN_I(cpin_i), .PORT_C_PIN_O(cpin),
      .PORT_C_PIN_OE_N_O(coen));
   pin_world u_pin_world (.pin_o_i(cpin), .oe_n_i(coen), .ext_i(ext),
      .pin_i_o(cpin_i));

   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         err_total = err_total + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input [15:0] got, input [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_total = err_total + 1;
      end
   endtask

   // The request is held until waitrequest is sampled low at a rising
   // edge; read data are taken at that same edge and only then is the
   // request released. A hang is ended by the cycle ceiling alone.
   task automatic bus(input w, input [11:0] a, input [15:0] d,
                      input [3:0] b, output [15:0] r);
      @(posedge clk);
      adr <= a;
      wdat <= {16'h0, d};
      be <= b;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
      end while (wt !== 1'b0);
      r = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr16(input [11:0] a, input [15:0] d, input [3:0] b);
      bus(1'b1, a, d, b, q);
   endtask

   task automatic rchk(input [11:0] a, input [15:0] exp);
      bus(1'b0, a, 16'h0, 4'h0, q);
      chk(q, exp);
   endtask

   task automatic do_reset();
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(coen, 16'hffff);
      rchk(12'hb38, 16'h0000);
      rchk(12'hb40, 16'h901e);
      rchk(12'hb58, 16'h0000);
   endtask

   function automatic [15:0] drv(input [15:0] d, l, o, e);
      drv = ~d & e & ~(o & l);
   endfunction

   function automatic [15:0] c_en(input [1:0] m, input f);
      c_en = 16'h001e;
      if (m == 2'h3 || m == 2'h0)
         c_en = c_en | (f ? 16'h9000 : 16'h1000);
   endfunction

   initial begin
      do_reset();
      wr16(12'hb40, 16'hffff, 4'hf);
      rchk(12'hb40, 16'h901e);
      wr16(12'hb58, 16'hffff, 4'hf);
      rchk(12'hb58, 16'hf01e);
      wr16(12'hb48, 16'hffff, 4'hf);
      rchk(12'hb50, 16'hf01e);
      wr16(12'hb38, 16'h1234, 4'h1);
      rchk(12'hb38, 16'h0034);
      wr16(12'hb30, 16'h5a5a, 4'hf);
      wr16(12'hb31, 16'hffff, 4'hf);
      wr16(12'hb60, 16'hffff, 4'hf);
      rchk(12'hb30, 16'h5a5a);
      rchk(12'hb60, 16'h0000);
      rchk(12'hb32, 16'h0000);
      bl = 16'h5a5a;
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge clk);
         mode <= (i < 8) ? i[1:0] : $random(seed);
         fn <= (i < 8) ? i[2] : $random(seed);
         bdir <= $random(seed);
         ext <= $random(seed);
         bb = $random(seed);
         wv = $random(seed);
         wr16(12'hb30, wv, bb);
         if (bb[0]) bl[7:0] = wv[7:0];
         if (bb[1]) bl[15:8] = wv[15:8];
         bo = $random(seed);
         cd = $random(seed);
         cl = $random(seed);
         co = $random(seed);
         wr16(12'hb38, bo, 4'hf);
         wr16(12'hb40, cd, 4'hf);
         wr16(12'hb50, cl, 4'hf);
         wr16(12'hb58, co, 4'hf);
         cd = cd & 16'h901e;
         cl = cl & 16'hf01e;
         co = co & 16'hf01e;
         repeat (3) @(posedge clk);
         en = c_en(mode, fn);
         dc = drv(cd, cl, co, en);
         chk(coen, ~dc);
         chk(cpin, cl & dc);
         chk(boen, ~drv(bdir, bl, bo, 16'hffff));
         chk(bpin, bl & drv(bdir, bl, bo, 16'hffff));
         wv = ((dc & cl) | (~dc & ext)) & (16'h601e | (en & 16'h9000));
         rchk(12'hb48, wv);
         rchk(12'hb50, cl);
         rchk(12'hb30, bl);
      end
      do_reset();
      wrap_up();
   end
endmodule
